// file: design/status_pkg.sv
// Package: register map, field layout and constants of the status readout block.
// Assumes a byte-wide register port decoded from a 16-bit SPI register address.
package status_pkg;
  localparam logic [15:0] status_byte0_addr = 16'h0205;
  localparam logic [15:0] status_byte1_addr = 16'h0206;
  localparam logic [15:0] status_byte2_addr = 16'h0207;
  localparam logic [15:0] status_select_addr = 16'h0306;
  localparam logic [15:0] base_address_low_addr = 16'h0307;
  localparam logic [15:0] base_address_high_addr = 16'h0308;
  localparam logic [15:0] otp_download_command_addr = 16'h0400;
  localparam logic [15:0] otp_default_first_addr = 16'h1000;
  localparam logic [15:0] otp_default_last_addr = 16'h1022;
  localparam int otp_default_count = 35;

  localparam logic [7:0] base_address_reset = 8'h00;
  localparam logic [3:0] select_reset = 4'h0;
  localparam logic [15:0] upper_reset = 16'h0000;
  localparam logic [7:0] cmd_otp_download = 8'h00;
  localparam logic [7:0] cmd_checksum = 8'hff;
  localparam logic [3:0] base_select_use_base = 4'hf;

  typedef enum logic [3:0] {
    sel_period = 4'h0, sel_rpm = 4'h1, sel_in_duty = 4'h2, sel_in_period = 4'h3,
    sel_in_high = 4'h4, sel_drive_target = 4'h5, sel_pi_duty = 4'h6,
    sel_energize_pos = 4'h7, sel_phase_conn = 4'h8, sel_crc = 4'h9,
    sel_max_duty = 4'ha, sel_lead_target = 4'hb, sel_lead_applied = 4'hc,
    sel_seq_state = 4'hd, sel_monitor_target = 4'he, sel_none = 4'hf
  } status_select_e;

  // Time base of the rotation period counter
  localparam int time_base_khz = 500;
  localparam int clock_khz = 250000;
  localparam int period_tick_cycles = 2 * clock_khz / time_base_khz;
  localparam int rpm_numerator = 60 * time_base_khz * 1000 / 2;
  localparam int duty_scale_shift = 10;

  localparam int period_w = 20;
  localparam int rpm_w = 15;
  localparam int duty_w = 10;
  localparam int pwm_count_w = 22;
  localparam int target_w = 15;
  localparam int lead_w = 5;
endpackage

// file: design/rotation_period_meter.sv
// Rotation period counter and rpm conversion.
// Assumes commutation_edge is a synchronous one-cycle pulse per electrical turn.
`timescale 1ns/1ps
module rotation_period_meter
  import status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic commutation_edge,
  output logic [period_w-1:0] rotation_period_count,
  output logic [rpm_w-1:0] rotation_rpm
);
  localparam logic [9:0] tick_last = 10'(period_tick_cycles - 1);
  localparam logic [period_w-1:0] period_max = '1;
  localparam logic [31:0] rpm_num = 32'(rpm_numerator);
  localparam logic [rpm_w-1:0] rpm_max = '1;

  logic [9:0] tick_q;
  logic [period_w-1:0] run_q;
  logic [31:0] quot;

  // One count per two periods of the time base
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= '0;
    end else if (clk_en) begin
      tick_q <= (tick_q == tick_last || commutation_edge) ? '0 : tick_q + 10'h001; // R5
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
      rotation_period_count <= '0;
    end else if (clk_en) begin
      if (commutation_edge) begin
        // A tick that lands on the closing edge still belongs to this period
        rotation_period_count <= (tick_q == tick_last && run_q != period_max) ?
                                 run_q + 20'h00001 : run_q; // R5
        run_q <= '0;
      end else if (tick_q == tick_last && run_q != period_max) begin
        run_q <= run_q + 20'h00001; // R5
      end
    end
  end

  // Divider kept combinational; a registered result follows one cycle later
  assign quot = (rotation_period_count == '0) ? 32'hffffffff :
                rpm_num / {12'h000, rotation_period_count};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rotation_rpm <= '0;
    end else if (clk_en) begin
      rotation_rpm <= (quot > {17'h00000, rpm_max}) ? rpm_max : quot[rpm_w-1:0]; // R6
    end
  end
endmodule

// file: design/status_readout.sv
// Status readout multiplexer, short-access base register and OTP command trigger.
// Assumes an SPI slave front end on ref_clk that issues one-cycle read and write
// strobes with a decoded 16-bit address; monitor values come from logic on ref_clk.
`timescale 1ns/1ps
// Behaviour
// R1: Status word as three consecutive byte registers
// R2: Low-byte read latches upper two bytes
// R3: Upper bytes read zero before first latch
// R4: Select 0 gives 20-bit rotation period
// R5: Period counts per two 500 kHz ticks
// R6: Select 1 gives 15-bit rpm, 60/period
// R7: Select 2 gives 10-bit input duty
// R8: Select 3/4 give input period, high counts
// R9: Select 5 gives 15-bit drive target
// R10: Select 6 gives 10-bit PI duty
// R11: Select 7 gives energizing position
// R12: Select 8 gives phase connection flags
// R13: Select 9 gives register CRC remainder
// R14: Select A gives max duty; clamps outputs
// R15: Select B gives lead angle target
// R16: Select C gives applied lead angle
// R17: Select D gives sequencer state bits
// R18: Select E gives monitor target, loop flag
// R19: Base register used when base-select is F
// R20: Command 00h downloads, FFh checksums
// R21: Commands ignored while OTP busy
// R22: OTP defaults readable at any time
// R23: Unassigned bits and select F read zero
module status_readout
  import status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [3:0] base_select_field,
  input wire logic [15:0] long_address,
  output logic [15:0] resolved_address,
  input wire logic commutation_edge,
  input wire logic [duty_w-1:0] input_pwm_duty,
  input wire logic [pwm_count_w-1:0] input_pwm_period_count,
  input wire logic [pwm_count_w-1:0] input_pwm_high_count,
  input wire logic [target_w-1:0] drive_target,
  input wire logic [duty_w-1:0] pi_output_duty,
  input wire logic [7:0] energizing_position,
  input wire logic [2:0] phase_connected,
  input wire logic [7:0] register_crc_remainder,
  input wire logic [duty_w-1:0] max_output_duty,
  input wire logic [duty_w-1:0] phase_duty_request,
  output logic [duty_w-1:0] phase_duty_clamped,
  input wire logic [lead_w-1:0] lead_angle_target,
  input wire logic [lead_w-1:0] lead_angle_applied,
  input wire logic window_change_active,
  input wire logic zero_cross_detect_active,
  input wire logic hiz_window_active,
  input wire logic [target_w-1:0] monitor_target,
  input wire logic closed_loop_indicator_n,
  input wire logic otp_busy_flag,
  output logic otp_download_start,
  output logic checksum_start,
  output logic otp_default_read,
  output logic [5:0] otp_default_index
);
  logic [3:0] select_q;
  logic [7:0] base_low_q;
  logic [7:0] base_high_q;
  logic [15:0] upper_q;
  logic [23:0] status_word;
  logic [period_w-1:0] rotation_period_count;
  logic [rpm_w-1:0] rotation_rpm;
  logic [7:0] rdata_d;
  logic hit_d;
  logic otp_region;

  rotation_period_meter meter (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .commutation_edge(commutation_edge),
    .rotation_period_count(rotation_period_count),
    .rotation_rpm(rotation_rpm)
  );

  // Source selection; every unlisted bit stays zero
  always_comb begin
    status_word = '0; // R23
    case (status_select_e'(select_q))
      sel_period: status_word[period_w-1:0] = rotation_period_count; // R4
      sel_rpm: status_word[rpm_w-1:0] = rotation_rpm; // R6
      sel_in_duty: status_word[duty_w-1:0] = input_pwm_duty; // R7
      sel_in_period: status_word[pwm_count_w-1:0] = input_pwm_period_count; // R8
      sel_in_high: status_word[pwm_count_w-1:0] = input_pwm_high_count; // R8
      sel_drive_target: status_word[target_w-1:0] = drive_target; // R9
      sel_pi_duty: status_word[duty_w-1:0] = pi_output_duty; // R10
      sel_energize_pos: status_word[7:0] = energizing_position; // R11
      sel_phase_conn: status_word[3:0] = {&phase_connected, phase_connected}; // R12
      sel_crc: status_word[7:0] = register_crc_remainder; // R13
      sel_max_duty: status_word[duty_w-1:0] = max_output_duty; // R14
      sel_lead_target: status_word[lead_w-1:0] = lead_angle_target; // R15
      sel_lead_applied: status_word[lead_w-1:0] = lead_angle_applied; // R16
      sel_seq_state: begin
        status_word[2:0] = {window_change_active, zero_cross_detect_active,
                            hiz_window_active}; // R17
      end
      sel_monitor_target: begin
        status_word[15:0] = {closed_loop_indicator_n, monitor_target}; // R18
      end
      default: status_word = '0; // R23
    endcase
  end

  // Duty clamp toward the phase outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_duty_clamped <= '0;
    end else if (clk_en) begin
      phase_duty_clamped <= (phase_duty_request > max_output_duty) ?
                            max_output_duty : phase_duty_request; // R14
    end
  end

  // Snapshot of upper bytes on low-byte read keeps the word coherent
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_q <= upper_reset; // R3
    end else if (clk_en) begin
      if (reg_read && reg_addr == status_byte0_addr) begin
        upper_q <= status_word[23:8]; // R2
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      select_q <= select_reset;
      base_low_q <= base_address_reset;
      base_high_q <= base_address_reset;
    end else if (clk_en && reg_write) begin
      if (reg_addr == status_select_addr) begin
        select_q <= reg_wdata[3:0]; // R1
      end
      if (reg_addr == base_address_low_addr) begin
        base_low_q <= reg_wdata; // R19
      end
      if (reg_addr == base_address_high_addr) begin
        base_high_q <= reg_wdata; // R19
      end
    end
  end

  // Address resolution for short-format frames
  always_comb begin
    resolved_address = (base_select_field == base_select_use_base) ?
                       {base_high_q, base_low_q} : long_address; // R19
  end

  // Command strobes; a busy OTP swallows the write entirely
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      otp_download_start <= 1'b0;
      checksum_start <= 1'b0;
    end else if (clk_en) begin
      otp_download_start <= 1'b0;
      checksum_start <= 1'b0;
      if (reg_write && reg_addr == otp_download_command_addr && !otp_busy_flag) begin // R21
        otp_download_start <= (reg_wdata == cmd_otp_download); // R20
        checksum_start <= (reg_wdata == cmd_checksum); // R20
      end
    end
  end

  // Defaults region is passed to the OTP array regardless of busy
  assign otp_region = reg_addr >= otp_default_first_addr &&
                      reg_addr <= otp_default_last_addr;

  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    case (reg_addr)
      status_byte0_addr: rdata_d = status_word[7:0]; // R1
      status_byte1_addr: rdata_d = upper_q[7:0]; // R2
      status_byte2_addr: rdata_d = upper_q[15:8]; // R2
      status_select_addr: rdata_d = {4'h0, select_q};
      base_address_low_addr: rdata_d = base_low_q;
      base_address_high_addr: rdata_d = base_high_q;
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      otp_default_read <= 1'b0;
      otp_default_index <= '0;
    end else if (clk_en) begin
      reg_hit <= reg_read && hit_d;
      otp_default_read <= reg_read && otp_region; // R22
      otp_default_index <= 6'(reg_addr - otp_default_first_addr);
      if (reg_read) begin
        reg_rdata <= rdata_d;
      end
    end
  end
endmodule

// file: verif/status_monitor.sv
// Checker: port-level properties of the status readout block.
// Assumes it is bound to status_readout and shares its clock and reset.
`timescale 1ns/1ps
module status_monitor
  import status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [3:0] base_select_field,
  input wire logic [15:0] long_address,
  input wire logic [15:0] resolved_address,
  input wire logic [duty_w-1:0] max_output_duty,
  input wire logic [duty_w-1:0] phase_duty_clamped,
  input wire logic otp_busy_flag,
  input wire logic otp_download_start,
  input wire logic checksum_start,
  input wire logic otp_default_read,
  input wire logic [5:0] otp_default_index
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence cmd_wr(v);
    clk_en && reg_write && reg_addr == otp_download_command_addr && reg_wdata == v;
  endsequence
  a_download_start: assert property (cmd_wr(cmd_otp_download) ##0 !otp_busy_flag |=>
    otp_download_start && !checksum_start) else $error("download start missing");
  a_checksum_start: assert property (cmd_wr(cmd_checksum) ##0 !otp_busy_flag |=>
    checksum_start && !otp_download_start) else $error("checksum start missing");
  a_busy_blocks: assert property (cmd_wr(cmd_otp_download) ##0 otp_busy_flag |=>
    !otp_download_start) else $error("command taken while busy");
  a_no_stray_start: assert property (!(clk_en && reg_write) |=>
    !otp_download_start && !checksum_start) else $error("start without write");
  a_base_bypass: assert property (base_select_field != base_select_use_base |->
    resolved_address == long_address) else $error("long address not passed");
  a_clamp_max: assert property ($past(clk_en) |->
    phase_duty_clamped <= $past(max_output_duty)) else $error("duty above maximum");
  a_unmapped_zero: assert property (clk_en && reg_read && reg_addr[15:12] == 4'h2 |=>
    reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read not zero");
  a_default_fetch: assert property (clk_en && reg_read &&
    reg_addr inside {[otp_default_first_addr:otp_default_last_addr]} |=>
    otp_default_read && otp_default_index == 6'($past(reg_addr)))
    else $error("default fetch wrong");
endmodule

// file: verif/spi_host_model.sv
// Partner: host issuing one-cycle register strobes on the shared clock.
// Assumes strobes are sampled on the rising edge and read data is registered.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic otp_default_read,
  input wire logic [5:0] otp_default_index,
  input wire logic otp_busy_flag,
  output logic reg_read,
  output logic reg_write,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata
);
  logic hit, dflt;
  logic [5:0] idx;
  initial begin
    reg_read = 0;
    reg_write = 0;
    reg_addr = 16'h0;
    reg_wdata = 8'h0;
  end
  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input bit obey = 1);
    while (obey && otp_busy_flag) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    reg_write = 1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge ref_clk);
    #1;
    reg_write = 0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    #1;
    reg_read = 1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    reg_read = 0;
    reg_addr = ~a;
    v = reg_rdata;
    hit = reg_hit;
    dflt = otp_default_read;
    idx = otp_default_index;
  endtask
endmodule

// file: verif/test_status_readout.sv
// Testbench: status word mux, base register and command trigger.
// Assumes the host model drives the register port; the checker is bound below.
`timescale 1ns/1ps
module test_status_readout
  import status_pkg::*;
;
  logic ref_clk = 0, rst_b = 0, clk_en = 1, commutation_edge = 0, otp_busy_flag = 0;
  logic reg_read, reg_write, reg_hit, otp_download_start, checksum_start, otp_default_read;
  logic [15:0] reg_addr, resolved_address, long_address = 16'h4321;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [3:0] base_select_field = 4'h0;
  logic [5:0] otp_default_index;
  logic [duty_w-1:0] input_pwm_duty = 10'h2a5, pi_output_duty = 10'h3c3;
  logic [duty_w-1:0] max_output_duty = 10'h2e7, phase_duty_request = 10'h3ff, phase_duty_clamped;
  logic [pwm_count_w-1:0] input_pwm_period_count = 22'h3abcde, input_pwm_high_count = 22'h1f0f0f;
  logic [target_w-1:0] drive_target = 15'h5a5a, monitor_target = 15'h6b3c;
  logic [7:0] energizing_position = 8'hbf, register_crc_remainder = 8'h9d;
  logic [2:0] phase_connected = 3'b101;
  logic [lead_w-1:0] lead_angle_target = 5'h1f, lead_angle_applied = 5'h0b;
  logic window_change_active = 1, zero_cross_detect_active = 0, hiz_window_active = 1;
  logic closed_loop_indicator_n = 1;
  logic [23:0] w;
  int n_mismatch = 0, cmp_count = 0, n_dl = 0, n_ck = 0;
  typedef struct packed { logic [3:0] sel; logic [23:0] word; } row_s;
  row_s rows [14] = '{'{4'h2, 24'h0002a5}, '{4'h3, 24'h3abcde}, '{4'h4, 24'h1f0f0f},
    '{4'h5, 24'h005a5a}, '{4'h6, 24'h0003c3}, '{4'h7, 24'h0000bf}, '{4'h8, 24'h000005},
    '{4'h9, 24'h00009d}, '{4'ha, 24'h0002e7}, '{4'hb, 24'h00001f}, '{4'hc, 24'h00000b},
    '{4'hd, 24'h000005}, '{4'he, 24'h00eb3c}, '{4'hf, 24'h000000}};
  status_readout dut (.*);
  spi_host_model host (.*);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_dl <= n_dl + int'(otp_download_start);
    n_ck <= n_ck + int'(checksum_start);
  end
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic read_word(output logic [23:0] v);
    host.rd(status_byte0_addr, v[7:0]);
    host.rd(status_byte1_addr, v[15:8]);
    host.rd(status_byte2_addr, v[23:16]);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_b = 1;
    host.rd(status_byte1_addr, d);
    check("byte1 after reset", {16'h0, d}, 24'h0);
    host.rd(status_byte2_addr, d);
    check("byte2 after reset", {16'h0, d}, 24'h0);
    host.rd(base_address_high_addr, d);
    check("base high reset", {15'h0, host.hit, d}, 24'h100);
    commutation_edge = 1;
    @(posedge ref_clk) #1 commutation_edge = 0;
    repeat (4999) @(posedge ref_clk);
    #1 commutation_edge = 1;
    @(posedge ref_clk) #1 commutation_edge = 0;
    host.wr(status_select_addr, 8'h00);
    read_word(w);
    check("period ticks", w, 24'h5);
    host.wr(status_select_addr, 8'h01);
    read_word(w);
    check("rpm", w, 24'h007fff);
    foreach (rows[i]) begin
      host.wr(status_select_addr, {4'h0, rows[i].sel});
      read_word(w);
      check("status word", w, rows[i].word);
    end
    host.wr(status_select_addr, 8'h03);
    host.rd(status_byte0_addr, d);
    host.wr(status_select_addr, 8'h04);
    host.rd(status_byte1_addr, d);
    check("held byte1", {16'h0, d}, 24'hbc);
    host.rd(status_byte2_addr, d);
    check("held byte2", {16'h0, d}, 24'h3a);
    clk_en = 0;
    host.wr(status_select_addr, 8'h07);
    clk_en = 1;
    host.rd(status_select_addr, d);
    check("frozen select", {16'h0, d}, 24'h04);
    rst_b = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1;
    host.rd(status_byte2_addr, d);
    check("byte2 after mid reset", {16'h0, d}, 24'h0);
    host.rd(status_select_addr, d);
    check("select after mid reset", {16'h0, d}, 24'h0);
    host.wr(base_address_low_addr, 8'h34);
    host.wr(base_address_high_addr, 8'h12);
    base_select_field = 4'hf;
    @(posedge ref_clk) check("short base", {8'h0, resolved_address}, 24'h1234);
    #1 base_select_field = 4'h3;
    @(posedge ref_clk) check("long address", {8'h0, resolved_address}, 24'h4321);
    host.wr(otp_download_command_addr, 8'h00);
    host.wr(otp_download_command_addr, 8'hff);
    host.wr(otp_download_command_addr, 8'h55);
    otp_busy_flag = 1;
    host.wr(otp_download_command_addr, 8'h00, 0);
    host.wr(otp_download_command_addr, 8'hff, 0);
    host.rd(16'h1022, d);
    check("default fetch", {17'h0, host.dflt, host.idx}, 24'h62);
    otp_busy_flag = 0;
    repeat (2) @(posedge ref_clk);
    check("command pulses", 24'(n_dl * 16 + n_ck), 24'h11);
    host.rd(16'h2000, d);
    check("unmapped read", {15'h0, host.hit, d}, 24'h0);
    check("clamped duty", {14'h0, phase_duty_clamped}, 24'h2e7);
    phase_duty_request = 10'h010;
    repeat (2) @(posedge ref_clk);
    #1 check("passed duty", {14'h0, phase_duty_clamped}, 24'h010);
    conclude();
  end
endmodule
bind status_readout status_monitor mon (.*);
